// ===== logic/owdp_link.sv
// Functional notes
// - Any error enters error state, halts bus
// - Error state drops everything except BREAK
// - Recovery done returns to normal instruction flow
// - Turnaround idle bits before first response byte
// - Each idle bit lasts one bit period
// - Guard is minimum; slow bus stretches it
// - At least two guard bits on our side
// - Training byte 0x55 sets the bit length
// - Direct read: address bytes, then sized data
// - Direct operands up to 32 bits
// - Direct read never auto-increments its address
// - Collected request handed to bus stage
// - Direct write: ack address, then ack data
// - Indirect read at pointer, or pointer itself
// - Pointer select 2 loads pointer, acknowledged
// - Select 0 stores, select 1 also advances
// - Indirect operands up to 32 bits
`timescale 1ns/1ps
`default_nettype none
`include "owdp_defines.svh"
module owdp_link import owdp_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// One-wire pin
	input wire logic wireIn,
	output logic wireOut,
	output logic wireOeN,
	// Configuration and status
	input wire logic [3:0] turnaroundIdleCount,
	output logic inError,
	output logic [2:0] errorCode,
	// System bus stage
	output owdp_bus_req_s busReq,
	output logic busValid,
	input wire owdp_bus_rsp_s busRsp
);
	owdp_rx_s rx;
	owdp_state_e st, after;
	logic contErr, txReady, txValid, recov;
	logic [7:0] txData, csByte;
	logic [2:0] op, opIn, txLeft, newCode;
	logic [1:0] fieldA, szB, cnt, ptrIn;
	logic [31:0] addr, wdata, ptr, txSh, addrNext, dataNext;
	logic [15:0] toCnt;
	logic toHit, busErrHit, badInstr, recBad, errAny, clearErr, goBus, isRead, addrLast;

	owdp_uart u_uart (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.pinIn(wireIn),
		.pinOut(wireOut),
		.pinOeN(wireOeN),
		.expectSynch(st == ST_BAUD_TRAINING_CHAR || st == ST_RSYNCH),
		.guardBits(turnaroundIdleCount),
		.rx(rx),
		.contErr(contErr),
		.txValid(txValid),
		.txData(txData),
		.txReady(txReady)
	);

	assign opIn = rx.data[`OWDP_OP_MSB:`OWDP_OP_LSB];
	assign ptrIn = rx.data[`OWDP_FA_MSB:`OWDP_FA_LSB];
	assign isRead = (op == `OWDP_OP_LDS) || (op == `OWDP_OP_LD);
	assign txValid = (st == ST_TX) && (txLeft != 3'h0);
	assign txData = txSh[7:0];

	// Sizes are all legal; reserved opcodes and pointer select 3 are not
	always_comb
	begin
		badInstr = 1'b0;
		if (st == ST_INSTR && rx.valid)
			unique case (opIn)
				`OWDP_OP_LDS, `OWDP_OP_STS, `OWDP_OP_CONTROL_SPACE_READ:
					badInstr = 1'b0;
				`OWDP_OP_LD, `OWDP_OP_ST:
					badInstr = (ptrIn == `OWDP_PTR_RSV);
				default:
					badInstr = 1'b1;
			endcase
	end

	assign recBad = (st == ST_RLDCS) && rx.valid && (opIn != `OWDP_OP_CONTROL_SPACE_READ);
	assign busErrHit = (st == ST_BUS) && busRsp.ack && busRsp.err;
	assign toHit = busValid && (toCnt == 16'(`OWDP_ACC_TO_CYC - 1));
	assign errAny = rx.parityErr | rx.frameErr | contErr | toHit | busErrHit | badInstr | recBad;
	assign clearErr = (st == ST_TX) && recov && (txLeft == 3'h0) && txReady;
	// Pointer select uses bits 3:2, so pointer loads are sized by the low field
	assign addrLast = cnt == ((op == `OWDP_OP_ST) ? szB : fieldA);

	always_comb
	begin
		if (contErr)
			newCode = `OWDP_ERR_CONT;
		else if (rx.parityErr)
			newCode = `OWDP_ERR_PARITY;
		else if (rx.frameErr)
			newCode = `OWDP_ERR_FRAME;
		else if (toHit)
			newCode = `OWDP_ERR_TIMEOUT;
		else if (busErrHit)
			newCode = `OWDP_ERR_BUS;
		else
			newCode = `OWDP_ERR_ILLEGAL;
	end

	// Control space readout
	always_comb
	begin
		unique case (rx.data[3:0])
			`OWDP_CS_CTRL:
				csByte = {4'h0, turnaroundIdleCount};
			`OWDP_CS_STAT:
				csByte = {inError, 4'h0, errorCode};
			default:
				csByte = 8'h00;
		endcase
	end

	// Little-endian byte assembly
	always_comb
	begin
		addrNext = addr;
		addrNext[{cnt, 3'h0} +: 8] = rx.data;
		dataNext = wdata;
		dataNext[{cnt, 3'h0} +: 8] = rx.data;
	end

	assign goBus = rx.valid && !errAny && !rx.brk && (
		(st == ST_INSTR && opIn == `OWDP_OP_LD && ptrIn != `OWDP_PTR_REG) ||
		(st == ST_ADDR && cnt == fieldA && op == `OWDP_OP_LDS) ||
		(st == ST_DATA && cnt == szB));

	// Error flag; a new error wins over the recovery clear
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			inError <= 1'b0;
			errorCode <= `OWDP_ERR_NONE;
		end
		else
		begin
			if (clearErr)
			begin
				inError <= 1'b0;
				errorCode <= `OWDP_ERR_NONE;
			end
			if (errAny && (!inError || clearErr))
			begin
				inError <= 1'b1;
				errorCode <= newCode;
			end
		end

	// Main sequencer
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			st <= ST_BAUD_TRAINING_CHAR;
			after <= ST_BAUD_TRAINING_CHAR;
			op <= 3'h0;
			fieldA <= 2'h0;
			szB <= 2'h0;
			cnt <= 2'h0;
			addr <= 32'h0;
			wdata <= 32'h0;
			txSh <= 32'h0;
			txLeft <= 3'h0;
			recov <= 1'b0;
		end
		else if (rx.brk)
		begin
			st <= inError ? ST_RSYNCH : ST_BAUD_TRAINING_CHAR;
			txLeft <= 3'h0;
			recov <= 1'b0;
		end
		else if (errAny)
		begin
			st <= ST_ERR;
			txLeft <= 3'h0;
			recov <= 1'b0;
		end
		else
			unique case (st)
				ST_BAUD_TRAINING_CHAR:
					if (rx.synchDone)
						st <= ST_INSTR;
				ST_RSYNCH:
					if (rx.synchDone)
						st <= ST_RLDCS;
				ST_INSTR:
					if (rx.valid)
					begin
						op <= opIn;
						fieldA <= ptrIn;
						szB <= rx.data[`OWDP_FB_MSB:`OWDP_FB_LSB];
						cnt <= 2'h0;
						addr <= 32'h0;
						wdata <= 32'h0;
						after <= ST_BAUD_TRAINING_CHAR;
						unique case (opIn)
							`OWDP_OP_LDS, `OWDP_OP_STS:
								st <= ST_ADDR;
							`OWDP_OP_LD:
								if (ptrIn == `OWDP_PTR_REG)
								begin
									txSh <= ptr;
									txLeft <= {1'b0, rx.data[`OWDP_FB_MSB:`OWDP_FB_LSB]} + 3'h1;
									st <= ST_TX;
								end
								else
									st <= ST_BUS;
							`OWDP_OP_ST:
								st <= (ptrIn == `OWDP_PTR_REG) ? ST_ADDR : ST_DATA;
							`OWDP_OP_CONTROL_SPACE_READ:
							begin
								txSh <= {24'h0, csByte};
								txLeft <= 3'h1;
								st <= ST_TX;
							end
							default:
								st <= ST_ERR;
						endcase
					end
				ST_ADDR:
					if (rx.valid)
					begin
						addr <= addrNext;
						cnt <= cnt + 2'h1;
						if (addrLast)
						begin
							cnt <= 2'h0;
							if (op == `OWDP_OP_LDS)
								st <= ST_BUS;
							else
							begin
								txSh <= {24'h0, `OWDP_ACK_CHAR};
								txLeft <= 3'h1;
								after <= (op == `OWDP_OP_STS) ? ST_DATA : ST_BAUD_TRAINING_CHAR;
								st <= ST_TX;
							end
						end
					end
				ST_DATA:
					if (rx.valid)
					begin
						wdata <= dataNext;
						cnt <= cnt + 2'h1;
						if (cnt == szB)
							st <= ST_BUS;
					end
				ST_BUS:
					if (busRsp.ack)
					begin
						if (isRead)
						begin
							txSh <= busRsp.rdata;
							txLeft <= {1'b0, szB} + 3'h1;
						end
						else
						begin
							txSh <= {24'h0, `OWDP_ACK_CHAR};
							txLeft <= 3'h1;
						end
						after <= ST_BAUD_TRAINING_CHAR;
						st <= ST_TX;
					end
				ST_TX:
					if (txLeft == 3'h0 && txReady)
					begin
						st <= after;
						recov <= 1'b0;
					end
					else if (txValid && txReady)
					begin
						txSh <= {8'h0, txSh[31:8]};
						txLeft <= txLeft - 3'h1;
					end
				ST_ERR:
					st <= ST_ERR;
				ST_RLDCS:
					if (rx.valid)
					begin
						txSh <= {24'h0, csByte};
						txLeft <= 3'h1;
						after <= ST_BAUD_TRAINING_CHAR;
						recov <= 1'b1;
						st <= ST_TX;
					end
				default:
					st <= ST_ERR;
			endcase

	// Address pointer
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			ptr <= 32'h0;
		else if (st == ST_ADDR && rx.valid && addrLast && op == `OWDP_OP_ST && !errAny && !rx.brk)
			ptr <= addrNext;
		else if (st == ST_BUS && busRsp.ack && !busRsp.err && op == `OWDP_OP_ST &&
			fieldA == `OWDP_PTR_INC)
			ptr <= ptr + {30'h0, szB} + 32'h1;

	// Bus request; dropped at once on error or break
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			busValid <= 1'b0;
			busReq <= '0;
		end
		else if (busValid)
		begin
			if (busRsp.ack || errAny || rx.brk)
				busValid <= 1'b0;
		end
		else if (goBus)
		begin
			busValid <= 1'b1;
			if (st == ST_INSTR)
			begin
				busReq.we <= 1'b0;
				busReq.size <= rx.data[`OWDP_FB_MSB:`OWDP_FB_LSB];
				busReq.addr <= ptr;
			end
			else if (st == ST_ADDR)
			begin
				busReq.we <= 1'b0;
				busReq.size <= szB;
				busReq.addr <= addrNext;
			end
			else
			begin
				busReq.we <= 1'b1;
				busReq.size <= szB;
				busReq.addr <= (op == `OWDP_OP_STS) ? addr : ptr;
				busReq.wdata <= dataNext;
			end
		end

	// Access time-out bounds the wait
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			toCnt <= 16'h0;
		else if (busValid && !busRsp.ack)
			toCnt <= toCnt + 16'h1;
		else
			toCnt <= 16'h0;
endmodule : owdp_link
`default_nettype wire

// ===== logic/owdp_defines.svh
`ifndef OWDP_DEFINES_SVH
`define OWDP_DEFINES_SVH
`define OWDP_CLK_NS 10
`define OWDP_ACC_TO_NS 20000
`define OWDP_ACC_TO_CYC (`OWDP_ACC_TO_NS / `OWDP_CLK_NS)
`define OWDP_BAUD_TRAINING_CHAR_CHAR 8'h55
`define OWDP_ACK_CHAR 8'h40
`define OWDP_MIN_GUARD 4'h2
`define OWDP_BIT_RST 16'h0064
`define OWDP_BIT_MIN 16'h0008
`define OWDP_OP_MSB 7
`define OWDP_OP_LSB 5
`define OWDP_FA_MSB 3
`define OWDP_FA_LSB 2
`define OWDP_FB_MSB 1
`define OWDP_FB_LSB 0
`define OWDP_OP_LDS 3'h0
`define OWDP_OP_LD 3'h1
`define OWDP_OP_STS 3'h2
`define OWDP_OP_ST 3'h3
`define OWDP_OP_CONTROL_SPACE_READ 3'h4
`define OWDP_PTR_AT 2'h0
`define OWDP_PTR_INC 2'h1
`define OWDP_PTR_REG 2'h2
`define OWDP_PTR_RSV 2'h3
`define OWDP_CS_CTRL 4'h0
`define OWDP_CS_STAT 4'h1
`define OWDP_ERR_NONE 3'h0
`define OWDP_ERR_PARITY 3'h1
`define OWDP_ERR_FRAME 3'h2
`define OWDP_ERR_CONT 3'h3
`define OWDP_ERR_TIMEOUT 3'h4
`define OWDP_ERR_BUS 3'h5
`define OWDP_ERR_ILLEGAL 3'h6
`endif

// ===== logic/owdp_pkg.sv
`default_nettype none
package owdp_pkg;
	typedef enum logic [3:0] {
		ST_BAUD_TRAINING_CHAR = 4'h0,
		ST_INSTR = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h3,
		ST_BUS = 4'h4,
		ST_TX = 4'h5,
		ST_ERR = 4'h6,
		ST_RSYNCH = 4'h7,
		ST_RLDCS = 4'h8
	} owdp_state_e;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_TRAIN = 2'h1, RX_BITS = 2'h2, RX_BRK = 2'h3} owdp_rxst_e;
	typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_GAP = 2'h1, TX_SHIFT = 2'h2} owdp_txst_e;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic parityErr;
		logic frameErr;
		logic brk;
		logic synchDone;
	} owdp_rx_s;
	typedef struct packed {
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} owdp_bus_req_s;
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} owdp_bus_rsp_s;
endpackage : owdp_pkg
`default_nettype wire

// ===== logic/owdp_uart.sv
`timescale 1ns/1ps
`default_nettype none
`include "owdp_defines.svh"
module owdp_uart import owdp_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Wire pin
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOeN,
	// Control
	input wire logic expectSynch,
	input wire logic [3:0] guardBits,
	// Receive side
	output owdp_rx_s rx,
	output logic contErr,
	// Transmit side
	input wire logic txValid,
	input wire logic [7:0] txData,
	output logic txReady
);
	logic s1, s2, s3, lvl, lvlD, fall, turn;
	owdp_rxst_e rxSt;
	owdp_txst_e txSt;
	logic [15:0] bitLen, rcnt, tcnt, half;
	logic [3:0] ridx, tidx;
	logic [2:0] edges;
	logic [9:0] rsh, nsh;
	logic [11:0] tsh;

	assign fall = lvlD & ~lvl;
	assign nsh = {lvl, rsh[9:1]};
	assign half = {1'b0, bitLen[15:1]};
	assign txReady = (txSt == TX_IDLE);

	// Three stages; level moves only when the last two agree
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			lvl <= 1'b1;
			lvlD <= 1'b1;
		end
		else
		begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				lvl <= s3;
			lvlD <= lvl;
		end

	// Receiver and baud training
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			rxSt <= RX_IDLE;
			rcnt <= 16'h0;
			ridx <= 4'h0;
			edges <= 3'h0;
			rsh <= 10'h0;
			bitLen <= `OWDP_BIT_RST;
			rx <= '0;
		end
		else
		begin
			rx <= '0;
			unique case (rxSt)
				RX_IDLE:
					if (fall && txSt == TX_IDLE)
					begin
						// Start at one so the fifth edge sees the whole span
						rcnt <= expectSynch ? 16'h1 : half;
						ridx <= 4'h0;
						edges <= 3'h0;
						rxSt <= expectSynch ? RX_TRAIN : RX_BITS;
					end
				RX_TRAIN:
				begin
					rcnt <= rcnt + 16'h1;
					// Five falling edges of the training byte span eight bits
					if (rcnt == 16'hffff)
					begin
						rx.frameErr <= 1'b1;
						rxSt <= RX_IDLE;
					end
					else if (fall)
					begin
						edges <= edges + 3'h1;
						if (edges == 3'h3)
						begin
							rxSt <= RX_IDLE;
							if ({3'h0, rcnt[15:3]} < `OWDP_BIT_MIN)
								rx.frameErr <= 1'b1;
							else
							begin
								bitLen <= {3'h0, rcnt[15:3]};
								rx.synchDone <= 1'b1;
							end
						end
					end
				end
				RX_BITS:
					if (rcnt != 16'h0)
						rcnt <= rcnt - 16'h1;
					else
					begin
						rcnt <= bitLen - 16'h1;
						ridx <= ridx + 4'h1;
						if (ridx == 4'h0)
						begin
							// Start bit gone at mid-bit: treat as a glitch
							if (lvl)
								rxSt <= RX_IDLE;
						end
						else
						begin
							rsh <= nsh;
							if (ridx == 4'ha)
							begin
								rx.data <= nsh[7:0];
								if (nsh == 10'h0)
									rxSt <= RX_BRK;
								else
								begin
									rxSt <= RX_IDLE;
									if (!nsh[9])
										rx.frameErr <= 1'b1;
									else if (^nsh[8:0])
										rx.parityErr <= 1'b1;
									else
										rx.valid <= 1'b1;
								end
							end
						end
					end
				RX_BRK:
					if (lvl)
					begin
						rx.brk <= 1'b1;
						rxSt <= RX_IDLE;
					end
			endcase
		end

	// Transmitter with turnaround idle bits
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			txSt <= TX_IDLE;
			tsh <= 12'hfff;
			tcnt <= 16'h0;
			tidx <= 4'h0;
			turn <= 1'b0;
			pinOut <= 1'b1;
			pinOeN <= 1'b1;
			contErr <= 1'b0;
		end
		else
		begin
			contErr <= 1'b0;
			if (rx.valid || rx.synchDone)
				turn <= 1'b1;
			unique case (txSt)
				TX_IDLE:
					if (txValid)
					begin
						tsh <= {2'b11, ^txData, txData, 1'b0};
						tcnt <= bitLen - 16'h1;
						pinOeN <= 1'b0;
						if (turn)
						begin
							// Never fewer than two idle bits on a turnaround
							tidx <= (guardBits < `OWDP_MIN_GUARD) ? `OWDP_MIN_GUARD : guardBits;
							turn <= 1'b0;
							pinOut <= 1'b1;
							txSt <= TX_GAP;
						end
						else
						begin
							tidx <= 4'hb;
							pinOut <= 1'b0;
							txSt <= TX_SHIFT;
						end
					end
				TX_GAP:
					if (tcnt != 16'h0)
						tcnt <= tcnt - 16'h1;
					else
					begin
						tcnt <= bitLen - 16'h1;
						if (tidx == 4'h1)
						begin
							tidx <= 4'hb;
							pinOut <= tsh[0];
							txSt <= TX_SHIFT;
						end
						else
							tidx <= tidx - 4'h1;
					end
				TX_SHIFT:
					if (tcnt != 16'h0)
					begin
						tcnt <= tcnt - 16'h1;
						if (tcnt == half && lvl != pinOut)
							contErr <= 1'b1;
					end
					else
					begin
						tcnt <= bitLen - 16'h1;
						tsh <= {1'b1, tsh[11:1]};
						pinOut <= tsh[1];
						if (tidx == 4'h0)
						begin
							pinOut <= 1'b1;
							pinOeN <= 1'b1;
							txSt <= TX_IDLE;
						end
						else
							tidx <= tidx - 4'h1;
					end
				default:
					txSt <= TX_IDLE;
			endcase
		end
endmodule : owdp_uart
`default_nettype wire

// ===== tb/owdp_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "owdp_defines.svh"
module owdp_link_properties import owdp_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Pin
	input wire logic wireIn,
	input wire logic wireOut,
	input wire logic wireOeN,
	// Status and bus
	input wire logic [3:0] turnaroundIdleCount,
	input wire logic inError,
	input wire logic [2:0] errorCode,
	input wire owdp_bus_req_s busReq,
	input wire logic busValid,
	input wire owdp_bus_rsp_s busRsp
);
	logic [11:0] waitCnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Cycles a request has waited
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			waitCnt <= 12'h000;
		else if (busValid && !busRsp.ack)
			waitCnt <= waitCnt + 12'h001;
		else
			waitCnt <= 12'h000;
	end
	a_err_stops_bus: assert property ($rose(inError) |=> !busValid)
		else $error("bus request kept after error");
	a_err_no_request: assert property (inError && !busValid |=> !busValid)
		else $error("bus request started in error state");
	a_ack_ends_req: assert property (busValid && busRsp.ack |=> !busValid)
		else $error("request not closed by ack");
	a_req_held: assert property (busValid && !busRsp.ack ##1 busValid |-> $stable(busReq))
		else $error("request changed while waiting");
	a_bus_err_code: assert property (busValid && busRsp.ack && busRsp.err && !inError
		|=> inError && errorCode == 3'h5)
		else $error("bus error not reported");
	a_wait_bound: assert property (waitCnt <= `OWDP_ACC_TO_CYC + 1)
		else $error("bus wait beyond time-out");
	// Back-to-back bytes release the pin for one cycle; that is no turnaround
	a_turn_idle: assert property ($fell(wireOeN) && $past(wireOeN, 2) |-> wireOut [*8])
		else $error("no idle bits before response");
	a_code_held: assert property (inError && $past(inError) |-> $stable(errorCode))
		else $error("error code changed in error state");
	a_clear_code: assert property ($fell(inError) |-> errorCode == 3'h0)
		else $error("error code left after recovery");
	c_write: cover property (busValid && busRsp.ack && busReq.we);
	c_err: cover property ($rose(inError));
	c_clear: cover property ($fell(inError));
	c_turn: cover property ($fell(wireOeN));
endmodule : owdp_link_properties
bind owdp_link owdp_link_properties chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .wireIn(wireIn),
	.wireOut(wireOut), .wireOeN(wireOeN), .turnaroundIdleCount(turnaroundIdleCount),
	.inError(inError), .errorCode(errorCode), .busReq(busReq), .busValid(busValid),
	.busRsp(busRsp));
`default_nettype wire

// ===== tb/owdp_dbg.sv
`timescale 1ns/1ps
`default_nettype none
module owdp_dbg (
	// Line
	input wire logic ref_clk,
	input wire logic lineIn,
	output logic lineDrv
);
	int bitLen = 16;
	// Released line floats to the pull-up
	initial lineDrv = 1'b1;
	// Guard bit, start, LSB first, even parity, stop
	task automatic send(input logic [7:0] b);
		logic [11:0] f;
		f = {1'b1, ^b, b, 1'b0, 1'b1};
		for (int i = 0; i < 12; i++)
		begin
			@(posedge ref_clk);
			#1 lineDrv = f[i];
			repeat (bitLen - 1) @(posedge ref_clk);
		end
	endtask : send
	task automatic brk();
		@(posedge ref_clk);
		#1 lineDrv = 1'b0;
		repeat (12 * bitLen) @(posedge ref_clk);
		#1 lineDrv = 1'b1;
		repeat (4 * bitLen) @(posedge ref_clk);
	endtask : brk
	// Returns at the end of the second stop bit
	task automatic recv(output logic [7:0] b);
		int w;
		w = 0;
		while (lineIn !== 1'b0 && w < 4000)
		begin
			@(posedge ref_clk);
			w++;
		end
		repeat (bitLen + bitLen / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = lineIn;
			repeat (bitLen) @(posedge ref_clk);
		end
		// Bad parity poisons the byte
		if (lineIn !== ^b)
			b = 8'hxx;
		repeat (2 * bitLen + bitLen / 2) @(posedge ref_clk);
	endtask : recv
endmodule : owdp_dbg
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "owdp_defines.svh"
module testbench import owdp_pkg::*;;
	typedef struct {logic [3:0] idle; logic [7:0] ins; logic [31:0] addr; logic [31:0] data;} owdp_row_s;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic wireOut, wireOeN, inError, busValid, dbgDrv, lineLvl;
	logic [3:0] idleCnt = 4'h3;
	logic [2:0] errorCode;
	owdp_bus_req_s busReq, lastReq;
	owdp_bus_rsp_s busRsp = '0;
	logic ackErr = 1'b0;
	logic noAck = 1'b0;
	logic gapArmed = 1'b1;
	int gapRun = 0;
	logic [31:0] ptr = 32'h0;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int busWait = 0;
	int gapCnt = 0;
	// Pointer is loaded before indirect reads
	owdp_row_s rows[13] = '{'{4'h0, 8'h00, 32'h5a, 32'h0}, '{4'h3, 8'h0f, 32'h89abcdef, 32'h0},
		'{4'h3, 8'h0f, 32'h89abcdef, 32'h0}, '{4'h1, 8'h09, 32'h123456, 32'h0},
		'{4'h4, 8'h4f, 32'h1000fffc, 32'hdeadbeef}, '{4'h2, 8'h44, 32'ha5c3, 32'h7e},
		'{4'h2, 8'h6b, 32'h2000, 32'h0}, '{4'h2, 8'h65, 32'h0, 32'hbeef},
		'{4'h2, 8'h60, 32'h0, 32'h33}, '{4'h2, 8'h27, 32'h0, 32'h0},
		'{4'h2, 8'h2b, 32'h0, 32'h0}, '{4'h2, 8'h21, 32'h0, 32'h0}, '{4'h6, 8'h80, 32'h0, 32'h0}};
	logic [7:0] badIns[4] = '{8'ha0, 8'hc0, 8'he0, 8'h6c};
	always #5 ref_clk = ~ref_clk;
	// Open-drain line with pull-up
	assign lineLvl = dbgDrv & (wireOeN | wireOut);
	owdp_link uut (.ref_clk(ref_clk), .arst_n(arst_n), .wireIn(lineLvl), .wireOut(wireOut),
		.wireOeN(wireOeN), .turnaroundIdleCount(idleCnt), .inError(inError),
		.errorCode(errorCode), .busReq(busReq), .busValid(busValid), .busRsp(busRsp));
	owdp_dbg dbg (.ref_clk(ref_clk), .lineIn(lineLvl), .lineDrv(dbgDrv));
	// Slow bus: ack on the fifth waiting cycle, never while hung
	always @(posedge ref_clk)
	begin
		#1 busRsp = '0;
		busWait = busValid ? busWait + 1 : 0;
		if (busWait == 5 && !noAck)
		begin
			busRsp = {1'b1, ackErr, ~busReq.addr};
			lastReq = busReq;
		end
	end
	// Idle run before the first start bit; a one-cycle release between bytes is skipped
	always @(posedge ref_clk)
	begin
		if (wireOeN)
		begin
			gapArmed = 1'b1;
			gapRun = 0;
		end
		else if (gapArmed && wireOut)
			gapRun++;
		else if (gapArmed)
		begin
			if (gapRun > 0)
				gapCnt = gapRun;
			gapArmed = 1'b0;
		end
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] msk(input logic [31:0] v, input int n);
		return v & (32'hffffffff >> (32 - 8 * n));
	endfunction : msk
	task automatic sendn(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			dbg.send(v[8 * i +: 8]);
	endtask : sendn
	task automatic recvn(output logic [31:0] v, input int n);
		int g;
		g = idleCnt < 4'h2 ? 2 : int'(idleCnt);
		v = '0;
		for (int i = 0; i < n; i++)
			dbg.recv(v[8 * i +: 8]);
		chk(gapCnt >= g * 16 && gapCnt <= g * 16 + 2, 1);
	endtask : recvn
	task automatic expectAck();
		logic [31:0] got;
		recvn(got, 1);
		chk(got, `OWDP_ACK_CHAR);
	endtask : expectAck
	task automatic xfer(input owdp_row_s r);
		logic [2:0] op;
		logic [1:0] sel;
		logic [31:0] a, got;
		logic direct;
		int nd;
		op = r.ins[7:5];
		sel = r.ins[3:2];
		nd = r.ins[1:0] + 1;
		direct = op == 3'h0 || op == 3'h2;
		idleCnt = r.idle;
		lastReq = '1;
		a = direct ? msk(r.addr, sel + 1) : ptr;
		dbg.send(8'h55);
		dbg.send(r.ins);
		if (direct)
			sendn(r.addr, sel + 1);
		if (op == 3'h2)
			expectAck();
		if (op == 3'h3 && sel == 2'h2)
			sendn(r.addr, nd);
		else if (op[2:1] == 2'h1)
			sendn(r.data, nd);
		if (op[2:1] == 2'h1)
			expectAck();
		else
		begin
			recvn(got, op == 3'h4 ? 1 : nd);
			chk(got, op == 3'h4 ? {28'h0, r.idle} :
				!direct && sel == 2'h2 ? msk(ptr, nd) : msk(~a, nd));
		end
		if (op == 3'h3 && sel == 2'h2)
			ptr = msk(r.addr, nd);
		else if (op != 3'h4 && (direct || sel != 2'h2))
		begin
			chk({lastReq.we, lastReq.size, lastReq.addr}, {op[1], r.ins[1:0], a});
			if (op[1])
				chk(lastReq.wdata, msk(r.data, nd));
			// Only writes advance the pointer
			if (op == 3'h3 && sel == 2'h1)
				ptr = ptr + 32'(nd);
		end
	endtask : xfer
	task automatic recover(input logic [2:0] code);
		logic [31:0] got;
		repeat (60) @(posedge ref_clk);
		#1 chk({inError, errorCode}, {1'b1, code});
		lastReq = '1;
		dbg.send(8'h55);
		dbg.send(8'h00);
		dbg.send(8'h11);
		repeat (60) @(posedge ref_clk);
		chk(lastReq.addr, 32'hffffffff);
		dbg.brk();
		dbg.send(8'h55);
		dbg.send(8'h81);
		recvn(got, 1);
		chk(got, {24'h0, 1'b1, 4'h0, code});
		repeat (60) @(posedge ref_clk);
		chk({inError, errorCode}, 4'h0);
	endtask : recover
	initial
	begin
		repeat (6) @(posedge ref_clk);
		chk({wireOut, wireOeN, inError, errorCode, busValid}, 7'h60);
		#1 arst_n = 1'b1;
		foreach (rows[i])
			xfer(rows[i]);
		foreach (badIns[i])
		begin
			dbg.send(8'h55);
			dbg.send(badIns[i]);
			recover(3'h6);
		end
		ackErr = 1'b1;
		dbg.send(8'h55);
		dbg.send(8'h00);
		dbg.send(8'h21);
		repeat (30) @(posedge ref_clk);
		#1 ackErr = 1'b0;
		recover(3'h5);
		// Hung bus must end in the access time-out
		noAck = 1'b1;
		dbg.send(8'h55);
		dbg.send(8'h00);
		dbg.send(8'h21);
		repeat (2100) @(posedge ref_clk);
		#1 noAck = 1'b0;
		recover(3'h4);
		xfer(rows[1]);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
